// ==== core/epc_defs.svh ====
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EPC_OFF_INTERRUPT_STATUS_0 16'hE502
`define EPC_OFF_INTERRUPT_MASK_0 16'hE50A
`define EPC_OFF_TERM 16'hE60E
`define EPC_OFF_FMODE 16'hE610
`define EPC_OFF_DEN1 16'hE611
`define EPC_OFF_DEN2 16'hE612
`define EPC_OFF_DEN3 16'hE613
`define EPC_OFF_CYC 16'hE705

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EPC_FIELD_W 3
`define EPC_TERM_LSB 0
`define EPC_SEL_LSB 0
`define EPC_DIS_LSB 9
`define EPC_LATCH_LSB 12
`define EPC_IRQ_LSB 14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPC_TERM_RST 16'h01FF
`define EPC_FMODE_RST 16'h0E88
`define EPC_DEN_RST 16'h0000
`define EPC_MASK_RST 32'h0000_0000
`define EPC_CYC_RST 8'h01

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EPC_CLK_HZ 40000000
`define EPC_LONG_LOW_MS 80
`define EPC_SHORT_LOW_US 1
`define EPC_LONG_LOW_CYC (`EPC_LONG_LOW_MS * (`EPC_CLK_HZ / 1000))
`define EPC_SHORT_LOW_CYC (`EPC_SHORT_LOW_US * (`EPC_CLK_HZ / 1000000))
`define EPC_TMR_W 22

`endif

// ==== core/epc_pkg.sv ====
`include "epc_defs.svh"

package epc_pkg;

    typedef enum logic [2:0] {
        EPC_PT_ACTIVE = 3'h0,
        EPC_PT_REACTIVE = 3'h1,
        EPC_PT_APPARENT = 3'h2,
        EPC_PT_FUND_ACT = 3'h3,
        EPC_PT_FUND_REACT = 3'h4
    } epc_power_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic low;
        logic fall;
        logic [`EPC_TMR_W-1:0] tmr;
    } epc_pulse_state_t;

    typedef struct packed {
        logic [7:0] edges;
        logic [4:0] strobe;
    } epc_latch_state_t;

    typedef struct packed {
        logic [15:0] term_sel;
        logic [15:0] fmode;
        logic [2:0][15:0] den;
        logic [31:0] mask;
        logic [2:0] cf_status;
        logic [7:0] latch_cycles;
        logic [31:0] rdata;
        logic [2:0] pin_n;
        logic irq_n;
    } epc_regs_t;

endpackage : epc_pkg

// ==== core/epc_pulse_gen.sv ====
`timescale 1ns/1ps
`include "epc_defs.svh"

module epc_pulse_gen #(
    parameter int LONG_LOW_CYC = `EPC_LONG_LOW_CYC,
    parameter int SHORT_LOW_CYC = `EPC_SHORT_LOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic active,
    input wire logic [1:0] inc,
    input wire logic [15:0] den,
    output logic conv_low,
    output logic fall
);

    localparam epc_pkg::epc_pulse_state_t RST_STATE = '{default: '0};

    epc_pkg::epc_pulse_state_t s_reg;
    epc_pkg::epc_pulse_state_t s_next;

    always_comb begin
        logic [16:0] eff;
        logic [16:0] sum;
        logic [16:0] half;
        eff = (den == 16'h0000) ? 17'h0_0001 : {1'b0, den};
        sum = {1'b0, s_reg.cnt} + {15'h0000, inc};
        half = 17'((eff + 17'h0_0001) >> 1);
        s_next = s_reg;
        s_next.fall = 1'b0;
        if (!active) begin
            // Idle converter holds high and forgets partial counts
            s_next.cnt = 16'h0000;
            s_next.low = 1'b0;
            s_next.tmr = '0;
        end else if (sum >= eff) begin
            s_next.cnt = (eff == 17'h0_0001) ? 16'h0000 : 16'(sum - eff);
            s_next.low = 1'b1;
            s_next.fall = 1'b1;
            s_next.tmr = '0;
        end else begin
            s_next.cnt = sum[15:0];
            if (s_reg.low) begin
                s_next.tmr = s_reg.tmr + `EPC_TMR_W'(1);
                if (eff == 17'h0_0001) begin
                    if (s_next.tmr >= `EPC_TMR_W'(SHORT_LOW_CYC)) begin
                        s_next.low = 1'b0;
                    end
                end else if ({1'b0, s_next.cnt} >= half) begin
                    s_next.low = 1'b0;
                end else if (s_next.tmr >= `EPC_TMR_W'(LONG_LOW_CYC)) begin
                    // Long periods reach this before the half count
                    s_next.low = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign conv_low = s_reg.low;
    assign fall = s_reg.fall;

endmodule : epc_pulse_gen

// ==== core/epc_latch.sv ====
`timescale 1ns/1ps

module epc_latch (
    input wire logic clk,
    input wire logic nrst,
    input wire logic fall,
    input wire logic enable,
    input wire logic [7:0] interval,
    input wire logic [2:0] sel,
    output logic [4:0] strobe
);

    localparam epc_pkg::epc_latch_state_t RST_STATE = '{default: '0};

    epc_pkg::epc_latch_state_t s_reg;
    epc_pkg::epc_latch_state_t s_next;

    always_comb begin
        logic [8:0] count;
        logic [8:0] limit;
        count = {1'b0, s_reg.edges} + 9'h001;
        // Zero interval behaves as one edge per latch
        limit = (interval == 8'h00) ? 9'h001 : {1'b0, interval};
        s_next = s_reg;
        s_next.strobe = 5'h00;
        if (!enable) begin
            s_next.edges = 8'h00;
        end else if (fall) begin
            if (count >= limit) begin
                s_next.edges = 8'h00;
                if (sel <= 3'h4) begin
                    s_next.strobe[sel] = 1'b1;
                end
            end else begin
                s_next.edges = count[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign strobe = s_reg.strobe;

endmodule : epc_latch

// ==== core/epc_top.sv ====
`timescale 1ns/1ps
`include "epc_defs.svh"

module epc_top #(
    parameter int LONG_LOW_CYC = `EPC_LONG_LOW_CYC,
    parameter int SHORT_LOW_CYC = `EPC_SHORT_LOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [2:0] active_pulse,
    input wire logic [2:0] reactive_pulse,
    input wire logic [2:0] apparent_pulse,
    input wire logic [2:0] fund_active_pulse,
    input wire logic [2:0] fund_reactive_pulse,
    input wire logic capture_port_enable,
    output logic freq_out_1_n,
    output logic freq_out_2_n,
    output logic freq_out_3_n,
    output logic interrupt_line_0_n,
    output logic [4:0] energy_latch_strobe
);

    // ----------------------------------------------------------------
    // Reset image of the register file
    // ----------------------------------------------------------------
    localparam epc_pkg::epc_regs_t RST_REGS = '{
        term_sel: `EPC_TERM_RST,
        fmode: `EPC_FMODE_RST,
        den: {`EPC_DEN_RST, `EPC_DEN_RST, `EPC_DEN_RST},
        mask: `EPC_MASK_RST,
        cf_status: 3'h0,
        latch_cycles: `EPC_CYC_RST,
        rdata: 32'h0000_0000,
        pin_n: 3'h7,
        irq_n: 1'b1
    };

    epc_pkg::epc_regs_t r_reg;
    epc_pkg::epc_regs_t r_next;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] field3(input logic [15:0] word, input int idx);
        field3 = word[idx*`EPC_FIELD_W +: `EPC_FIELD_W];
    endfunction : field3

    function automatic logic [2:0] pick_type(
        input logic [2:0] sel,
        input logic [2:0] act,
        input logic [2:0] react,
        input logic [2:0] app,
        input logic [2:0] fact,
        input logic [2:0] freact
    );
        case (sel)
            epc_pkg::EPC_PT_ACTIVE: pick_type = act;
            epc_pkg::EPC_PT_REACTIVE: pick_type = react;
            epc_pkg::EPC_PT_APPARENT: pick_type = app;
            epc_pkg::EPC_PT_FUND_ACT: pick_type = fact;
            epc_pkg::EPC_PT_FUND_REACT: pick_type = freact;
            default: pick_type = 3'h0;
        endcase
    endfunction : pick_type

    function automatic logic [1:0] count3(input logic [2:0] v);
        count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    endfunction : count3

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
        hit = (addr == off);
    endfunction : hit

    // ----------------------------------------------------------------
    // Converters
    // ----------------------------------------------------------------
    logic [2:0] conv_active;
    logic [2:0] conv_low;
    logic [2:0] conv_fall;
    logic [2:0][1:0] conv_inc;
    logic [2:0][4:0] conv_strobe;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_conv
            logic [2:0] sel;
            logic [2:0] phases;
            logic [2:0] picked;
            assign sel = field3(r_reg.fmode, gi);
            assign phases = field3(r_reg.term_sel, gi);
            assign picked = pick_type(sel, active_pulse, reactive_pulse, apparent_pulse,
                fund_active_pulse, fund_reactive_pulse);
            // Summing up to three phase pulses in one cycle keeps them all, except with den 0 or 1, where they give one output pulse
            assign conv_inc[gi] = count3(picked & phases);
            assign conv_active[gi] = (phases != 3'h0) && (sel <= 3'h4);

            epc_pulse_gen #(
                .LONG_LOW_CYC(LONG_LOW_CYC),
                .SHORT_LOW_CYC(SHORT_LOW_CYC)
            ) u_pulse (
                .clk(clk),
                .nrst(nrst),
                .active(conv_active[gi]),
                .inc(conv_inc[gi]),
                .den(r_reg.den[gi]),
                .conv_low(conv_low[gi]),
                .fall(conv_fall[gi])
            );

            epc_latch u_latch (
                .clk(clk),
                .nrst(nrst),
                .fall(conv_fall[gi]),
                .enable(r_reg.fmode[`EPC_LATCH_LSB + gi] && conv_active[gi]),
                .interval(r_reg.latch_cycles),
                .sel(sel),
                .strobe(conv_strobe[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register file and pins
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] set_st;
        logic [2:0] clr_st;
        set_st = 3'h0;
        clr_st = 3'h0;
        r_next = r_reg;

        // Status is set only for unmasked edges, pin state ignored
        for (int i = 0; i < 3; i++) begin
            set_st[i] = conv_fall[i] && r_reg.mask[`EPC_IRQ_LSB + i];
        end

        if (reg_wr) begin
            if (hit(reg_addr, `EPC_OFF_INTERRUPT_STATUS_0)) begin
                clr_st = reg_wdata[`EPC_IRQ_LSB +: 3];
            end
            if (hit(reg_addr, `EPC_OFF_INTERRUPT_MASK_0)) begin
                r_next.mask = reg_wdata;
            end
            if (hit(reg_addr, `EPC_OFF_TERM)) begin
                r_next.term_sel = reg_wdata[15:0];
            end
            if (hit(reg_addr, `EPC_OFF_FMODE)) begin
                r_next.fmode = reg_wdata[15:0];
            end
            if (hit(reg_addr, `EPC_OFF_DEN1)) begin
                r_next.den[0] = reg_wdata[15:0];
            end
            if (hit(reg_addr, `EPC_OFF_DEN2)) begin
                r_next.den[1] = reg_wdata[15:0];
            end
            if (hit(reg_addr, `EPC_OFF_DEN3)) begin
                r_next.den[2] = reg_wdata[15:0];
            end
            if (hit(reg_addr, `EPC_OFF_CYC)) begin
                r_next.latch_cycles = reg_wdata[7:0];
            end
        end

        // New edge in the clearing cycle survives
        r_next.cf_status = (r_reg.cf_status & ~clr_st) | set_st;
        r_next.irq_n = ~|(r_next.cf_status & r_next.mask[`EPC_IRQ_LSB +: 3]);

        if (reg_rd) begin
            r_next.rdata = 32'h0000_0000;
            if (hit(reg_addr, `EPC_OFF_INTERRUPT_STATUS_0)) begin
                r_next.rdata[`EPC_IRQ_LSB +: 3] = r_reg.cf_status;
            end
            if (hit(reg_addr, `EPC_OFF_INTERRUPT_MASK_0)) begin
                r_next.rdata = r_reg.mask;
            end
            if (hit(reg_addr, `EPC_OFF_TERM)) begin
                r_next.rdata[15:0] = r_reg.term_sel;
            end
            if (hit(reg_addr, `EPC_OFF_FMODE)) begin
                r_next.rdata[15:0] = r_reg.fmode;
            end
            if (hit(reg_addr, `EPC_OFF_DEN1)) begin
                r_next.rdata[15:0] = r_reg.den[0];
            end
            if (hit(reg_addr, `EPC_OFF_DEN2)) begin
                r_next.rdata[15:0] = r_reg.den[1];
            end
            if (hit(reg_addr, `EPC_OFF_DEN3)) begin
                r_next.rdata[15:0] = r_reg.den[2];
            end
            if (hit(reg_addr, `EPC_OFF_CYC)) begin
                r_next.rdata[7:0] = r_reg.latch_cycles;
            end
        end

        // Pins follow the converter one cycle later, high when disabled
        for (int i = 0; i < 3; i++) begin
            r_next.pin_n[i] = r_reg.fmode[`EPC_DIS_LSB + i] | ~conv_low[i];
        end
        if (capture_port_enable) begin
            // Pin belongs to the capture clock; converter keeps running
            r_next.pin_n[2] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= RST_REGS;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = r_reg.rdata;
    assign freq_out_1_n = r_reg.pin_n[0];
    assign freq_out_2_n = r_reg.pin_n[1];
    assign freq_out_3_n = r_reg.pin_n[2];
    assign interrupt_line_0_n = r_reg.irq_n;
    // Accumulator block copies then clears all three phases of each type
    assign energy_latch_strobe = conv_strobe[0] | conv_strobe[1] | conv_strobe[2];

endmodule : epc_top

// ==== verif/epc_checker_sva.sv ====
`timescale 1ns/1ps
module epc_checker #(
    parameter int LONG_LOW_CYC = 200
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic capture_port_enable,
    input wire logic freq_out_1_n,
    input wire logic freq_out_2_n,
    input wire logic freq_out_3_n,
    input wire logic interrupt_line_0_n,
    input wire logic [4:0] energy_latch_strobe
);
    // ------
    // Shadows of written registers, pin 1 low counter
    // ------
    logic [15:0] fmode_reg;
    logic [2:0] mask_reg;
    int low_reg;
    logic known;
    assign known = reg_addr inside {16'he502, 16'he50a, 16'he60e, 16'he610, 16'he611,
        16'he612, 16'he613, 16'he705};
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fmode_reg <= 16'h0e88;
            mask_reg <= 3'h0;
            low_reg <= 0;
        end else begin
            if (reg_wr && reg_addr == 16'he610)
                fmode_reg <= reg_wdata[15:0];
            if (reg_wr && reg_addr == 16'he50a)
                mask_reg <= reg_wdata[16:14];
            low_reg <= freq_out_1_n ? 0 : low_reg + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_flagged_fall;
        $fell(freq_out_1_n) && mask_reg[0];
    endsequence
    sequence s_mask_clear;
        (mask_reg == 3'h0) [*2];
    endsequence
    cap_pin_off_a: assert property (capture_port_enable |=> freq_out_3_n)
        else $error("pin 3 low while capture port owns it");
    dis_pin_one_a: assert property (fmode_reg[9] |=> freq_out_1_n)
        else $error("pin 1 low while disabled");
    dis_pin_two_a: assert property (fmode_reg[10] |=> freq_out_2_n)
        else $error("pin 2 low while disabled");
    fall_irq_a: assert property (s_flagged_fall |-> !interrupt_line_0_n)
        else $error("enabled fall did not raise interrupt");
    irq_masked_a: assert property (s_mask_clear |-> interrupt_line_0_n)
        else $error("interrupt low with all converter masks clear");
    mode_read_a: assert property (reg_rd && !reg_wr && reg_addr == 16'he610
        |=> reg_rdata == {16'h0000, fmode_reg}) else $error("mode register readback wrong");
    unmapped_read_a: assert property (reg_rd && !known |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    latch_off_a: assert property ((fmode_reg[14:12] == 3'h0) [*2]
        |-> energy_latch_strobe == 5'h00) else $error("strobe with latching off");
    strobe_once_a: assert property ($rose(energy_latch_strobe[2])
        |=> !energy_latch_strobe[2]) else $error("latch strobe longer than one cycle");
    long_low_a: assert property (low_reg <= LONG_LOW_CYC + 1)
        else $error("pin 1 low past the long limit");
endmodule : epc_checker
bind epc_top epc_checker #(.LONG_LOW_CYC(LONG_LOW_CYC)) epc_checker_inst (.*);

// ==== verif/epc_meter_probe.sv ====
`timescale 1ns/1ps
module epc_meter_probe (
    input wire logic clk,
    input wire logic pin_n,
    output int falls,
    output int low_len
);
    // ------
    // Optical pickup: counts flashes, times each
    // ------
    logic last_n = 1'b1;
    int run = 0;
    initial begin
        falls = 0;
        low_len = 0;
    end
    always @(posedge clk) begin
        last_n <= pin_n;
        if (last_n === 1'b1 && pin_n === 1'b0)
            falls <= falls + 1;
        if (pin_n === 1'b0)
            run <= run + 1;
        else if (last_n === 1'b0) begin
            low_len <= run;
            run <= 0;
        end
    end
endmodule : epc_meter_probe

// ==== verif/energy_to_pulse_converter_bench.sv ====
`timescale 1ns/1ps
module energy_to_pulse_converter_bench;
    localparam int LONG = 200;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0] pulse [5] = '{default: 3'h0};
    logic cap = 1'b0;
    logic [2:0] pin_n;
    logic irq_n;
    logic [4:0] strobe;
    int falls [3];
    int low_len [3];
    int num_errors = 0;
    int samples_checked = 0;
    int strobes = 0;
    int stray = 0;

    always #12.5 clk = ~clk;
    // Only the apparent type is ever latched, so any other strobe bit is stray
    always @(posedge clk) begin
        if (strobe[2] === 1'b1)
            strobes <= strobes + 1;
        if (nrst && (strobe & 5'h1b) !== 5'h00)
            stray <= stray + 1;
    end

    epc_top #(.LONG_LOW_CYC(LONG), .SHORT_LOW_CYC(4)) epc_top_inst (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .active_pulse(pulse[0]), .reactive_pulse(pulse[1]), .apparent_pulse(pulse[2]),
        .fund_active_pulse(pulse[3]), .fund_reactive_pulse(pulse[4]),
        .capture_port_enable(cap), .freq_out_1_n(pin_n[0]), .freq_out_2_n(pin_n[1]),
        .freq_out_3_n(pin_n[2]), .interrupt_line_0_n(irq_n), .energy_latch_strobe(strobe));
    for (genvar i = 0; i < 3; i++) begin : g_probe
        epc_meter_probe epc_meter_probe_inst (.clk(clk), .pin_n(pin_n[i]),
            .falls(falls[i]), .low_len(low_len[i]));
    end

    // ------
    // Access and stimulus tasks
    // ------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Extra edge at the end keeps back-to-back writes from colliding
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp);
        @(posedge clk);
    endtask : rd

    task automatic fire(input int ty, input logic [2:0] ph, input int n, input int gap);
        repeat (n) begin
            pulse[ty] <= ph;
            @(posedge clk);
            pulse[ty] <= 3'h0;
            repeat (gap - 1) @(posedge clk);
        end
    endtask : fire

    // Empty phase select first: clears leftover counts between cases
    task automatic run(input logic [15:0] term, input int ty, input logic [2:0] ph,
            input int n, input int gap, input int e0, input int e1, input int e2);
        int base [3];
        wr(16'he60e, 32'h0000_0000);
        wr(16'he60e, {16'h0000, term});
        base = falls;
        fire(ty, ph, n, gap);
        repeat (20) @(posedge clk);
        check(32'(falls[0] - base[0]), 32'(e0));
        check(32'(falls[1] - base[1]), 32'(e1));
        check(32'(falls[2] - base[2]), 32'(e2));
    endtask : run

    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // ------
    // Scenarios
    // ------
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(16'he60e, 32'h0000_01ff);
        rd(16'he610, 32'h0000_0e88);
        rd(16'h1234, 32'h0000_0000);
        wr(16'he50a, 32'h0000_4000);
        rd(16'he50a, 32'h0000_4000);
        fire(0, 3'h1, 1, 8);
        check(32'(pin_n), 32'h0000_0007);
        rd(16'he502, 32'h0000_4000);
        check(32'(irq_n), 32'h0000_0000);
        wr(16'he502, 32'h0000_4000);
        rd(16'he502, 32'h0000_0000);
        check(32'(irq_n), 32'h0000_0001);
        wr(16'he611, 32'h0000_0004);
        wr(16'he612, 32'h0000_0003);
        for (int c = 0; c < 8; c++) begin
            wr(16'he610, 32'(c * 73));
            for (int t = 0; t < 5; t++) begin
                run(16'h01ff, t, 3'h1, 4, 10, int'(c == t), int'(c == t), 4 * int'(c == t));
            end
        end
        wr(16'he610, 32'h0000_0000);
        run(16'h01ff, 0, 3'h1, 12, 10, 3, 4, 12);
        check(32'(low_len[0]), 32'h0000_0014);
        check(32'(low_len[1]), 32'h0000_0014);
        check(32'(low_len[2]), 32'h0000_0004);
        run(16'h0182, 0, 3'h1, 4, 10, 0, 0, 0);
        run(16'h0182, 0, 3'h2, 4, 10, 1, 0, 4);
        // A divide step reached while still low extends that low: no new pin edge
        run(16'h01ff, 0, 3'h7, 4, 10, 2, 1, 4);
        cap <= 1'b1;
        run(16'h01ff, 0, 3'h1, 4, 10, 1, 1, 0);
        cap <= 1'b0;
        wr(16'he611, 32'h0000_0002);
        run(16'h01ff, 0, 3'h1, 4, 300, 2, 1, 4);
        check(32'(low_len[0]), 32'(LONG));
        check(32'(strobes), 32'h0000_0000);
        wr(16'he705, 32'h0000_0002);
        wr(16'he610, 32'h0000_1002);
        run(16'h01ff, 2, 3'h1, 8, 10, 4, 0, 0);
        check(32'(strobes), 32'h0000_0002);
        wr(16'he610, 32'h0000_0088);
        rd(16'he502, 32'h0000_4000);
        wr(16'he502, 32'h0001_c000);
        wr(16'he50a, 32'h0001_c000);
        run(16'h01ff, 1, 3'h1, 4, 10, 0, 1, 0);
        rd(16'he502, 32'h0000_8000);
        check(32'(irq_n), 32'h0000_0000);
        check(32'(stray), 32'h0000_0000);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule : energy_to_pulse_converter_bench
